// ==== hdl/hir_params.svh ====
// Constants for the host isolation, reset and auxiliary sense block.
`ifndef HIR_PARAMS_SVH
`define HIR_PARAMS_SVH

// Clock rate of i_clk in MHz.
`define HIR_CLK_MHZ          125
// Settling time of the shared pin before the auxiliary sample, in ns.
`define HIR_AUX_SETTLE_NS    1000
// Least settling time rounded up to whole clock cycles.
`define HIR_AUX_SETTLE_CYC   (((`HIR_AUX_SETTLE_NS) * (`HIR_CLK_MHZ) + 999) / 1000)
// Width of the settle counter.
`define HIR_CNT_W            8
// Reset value of the settle counter.
`define HIR_CNT_RST          8'h00
// Auxiliary current capability reported when auxiliary power is present.
`define HIR_AUX_CURRENT_CAP  3'h1
// Auxiliary current capability reported when auxiliary power is absent.
`define HIR_AUX_CURRENT_NONE 3'h0
// Idle value of byte-wide bus data.
`define HIR_BYTE_IDLE        8'h00

`endif

// ==== hdl/hir_pkg.sv ====
// Types shared by the host isolation, reset and auxiliary sense block.
`default_nettype none

package hir_pkg;

  typedef logic [7:0] hir_byte_t;
  typedef logic [2:0] hir_aux_cur_t;
  typedef logic [7:0] hir_cnt_t;

  // Sequencer states of the top module.
  typedef enum logic [1:0]
  {
    ST_HOST_RESET,
    ST_WAIT_AUX,
    ST_READY
  } hir_state_e;

  // All state of the top module.
  typedef struct packed
  {
    hir_state_e   state;
    logic         aux_start;
    logic         wake_pend;
    logic         wake_lvl;
    logic         tx_en;
    logic         tx_valid;
    hir_byte_t    tx_data;
    logic         rx_valid;
    hir_byte_t    rx_data;
    logic         cfg_ready;
    logic         pin_oe;
    logic         pin_out;
    logic         aux_present;
    logic         pme_d3cold;
    hir_aux_cur_t aux_current;
  } hir_top_s;

  // All state of the auxiliary sampler.
  typedef struct packed
  {
    hir_cnt_t cnt;
    logic     done;
    logic     present;
    logic     oe;
  } hir_aux_s;

endpackage

`default_nettype wire

// ==== hdl/hir_aux_if.sv ====
// Interface between the sequencer and the auxiliary power sampler.
`timescale 1ns/1ns
`default_nettype none

interface hir_aux_if;
  logic pin_in;
  logic start;
  logic done;
  logic present;
  logic oe;

  modport sampler (input pin_in, input start, output done, output present, output oe);
  modport ctrl    (output pin_in, output start, input done, input present, input oe);
endinterface

`default_nettype wire

// ==== hdl/hir_aux_sense.sv ====
// Power-on sampler of the shared serial-data / auxiliary-sense pin.
`timescale 1ns/1ns
`default_nettype none
`include "hir_params.svh"

module hir_aux_sense
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  hir_aux_if.sampler aif
);
  import hir_pkg::*;

  localparam hir_cnt_t SETTLE_LAST = hir_cnt_t'(`HIR_AUX_SETTLE_CYC - 1);

  hir_aux_s q;
  hir_aux_s next_q;

  ////////////////////////////////////////////////////////////////////////////
  // The pin stays an input until the settle time is over, then the level is
  // caught once and the pin turns into an output. The result is never taken
  // again, so later traffic on the pin cannot change the capability bits.
  always_comb
  begin
    next_q = q;
    if (aif.start && !q.done)
    begin
      if (q.cnt == SETTLE_LAST)
      begin
        next_q.done    = 1'b1;
        next_q.present = aif.pin_in;
        next_q.oe      = 1'b1;
      end
      else
      begin
        next_q.cnt = q.cnt + 8'h01;
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q     <= '0;
      q.cnt <= `HIR_CNT_RST;
    end
    else if (i_ce)
    begin
      q <= next_q;
    end
  end

  assign aif.done    = q.done;
  assign aif.present = q.present;
  assign aif.oe      = q.oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sampler.
  a_aux_level_caught:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(q.done) |-> (q.present == $past(aif.pin_in)))
    else $error("Auxiliary sample does not match the pin level.");

  a_pin_input_first:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !q.done |-> !q.oe)
    else $error("Shared pin driven before the auxiliary sample.");

  a_pin_output_after:
    assert property (@(posedge i_clk) disable iff (!i_rst_n)
      q.done |=> (q.oe && q.done && $stable(q.present)))
    else $error("Shared pin left output mode or sample changed.");

endmodule

`default_nettype wire

// ==== hdl/hir_top.sv ====
// Host reset, bus isolation, wake output and auxiliary power sense sequencer.
//
// Overview of operation
// - Wake event pulls open-drain wake output low.
// - Isolate low: no host-bus drive, inputs ignored.
// - Host reset enters reset; configure only afterwards.
// - Sample shared pin at power-on; high means aux.
// - Aux result sets power-management capability bits.
`timescale 1ns/1ns
`default_nettype none
`include "hir_params.svh"

module hir_top
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_ce,
  input  wire logic                  i_host_fundamental_reset_n,
  input  wire logic                  i_bus_isolate_n,
  input  wire logic                  i_host_rx_valid,
  input  wire hir_pkg::hir_byte_t    i_host_rx_data,
  input  wire logic                  i_core_tx_valid,
  input  wire hir_pkg::hir_byte_t    i_core_tx_data,
  input  wire logic                  i_wake_event,
  input  wire logic                  i_main_power_good,
  input  wire logic                  i_cfg_mem_serial_out,
  input  wire logic                  i_serial_out_aux_sense_i,
  output var  logic                  o_serial_out_aux_sense_o,
  output var  logic                  o_serial_out_aux_sense_oe,
  output var  logic                  o_pm_wake_event_n_o,
  output var  logic                  o_pm_wake_event_n_oe,
  output var  logic                  o_host_tx_en,
  output var  logic                  o_host_tx_valid,
  output var  hir_pkg::hir_byte_t    o_host_tx_data,
  output var  logic                  o_core_rx_valid,
  output var  hir_pkg::hir_byte_t    o_core_rx_data,
  output var  logic                  o_cfg_ready,
  output var  logic                  o_aux_power_present,
  output var  logic                  o_pm_cap_d3cold_pme,
  output var  hir_pkg::hir_aux_cur_t o_pm_cap_aux_current
);
  import hir_pkg::*;

  hir_top_s q;
  hir_top_s next_q;
  hir_aux_if aif ();

  ////////////////////////////////////////////////////////////////////////////
  // The host bus is open only when the block is out of reset, has finished
  // the power-on sense and is not isolated. Used for both directions.
  function automatic logic bus_open(input logic iso_n,
                                    input logic rst_n,
                                    input hir_state_e st);
    bus_open = iso_n && rst_n && (st == ST_READY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Auxiliary power sampler; it starts once after power-on reset.
  assign aif.pin_in = i_serial_out_aux_sense_i;
  assign aif.start  = q.aux_start;

  hir_aux_sense u_aux_sense
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .aif     (aif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block.
  always_comb
  begin
    next_q           = q;
    next_q.aux_start = 1'b1;

    // Sequencer: hold in reset, wait for the sense result, then run.
    case (q.state)
      ST_HOST_RESET:
      begin
        if (i_host_fundamental_reset_n)
        begin
          next_q.state = ST_WAIT_AUX;
        end
      end
      ST_WAIT_AUX:
      begin
        if (aif.done)
        begin
          next_q.state = ST_READY;
        end
      end
      ST_READY:
      begin
        next_q.state = ST_READY;
      end
      default:
      begin
        next_q.state = ST_HOST_RESET;
      end
    endcase
    // A host reset overrides every state, even mid-sequence.
    if (!i_host_fundamental_reset_n)
    begin
      next_q.state = ST_HOST_RESET;
    end
    // Configuration is accepted only once out of host reset.
    next_q.cfg_ready = (next_q.state == ST_READY);

    // Host transmit path: no drive while isolated or in reset.
    next_q.tx_en    = bus_open(i_bus_isolate_n, i_host_fundamental_reset_n, q.state);
    next_q.tx_valid = next_q.tx_en && i_core_tx_valid;
    next_q.tx_data  = next_q.tx_valid ? i_core_tx_data : `HIR_BYTE_IDLE;

    // Host receive path: inputs are ignored while isolated.
    next_q.rx_valid = bus_open(i_bus_isolate_n, i_host_fundamental_reset_n, q.state)
                      && i_host_rx_valid;
    next_q.rx_data  = next_q.rx_valid ? i_host_rx_data : `HIR_BYTE_IDLE;

    // Wake request stays until the system reports main power back. A new
    // event in the same cycle as the clear wins, so no request is lost.
    // Isolation does not touch this path on purpose.
    next_q.wake_pend = i_wake_event || (q.wake_pend && !i_main_power_good);
    next_q.wake_lvl  = 1'b0;

    // Capability bits follow the sense result with no software step.
    next_q.aux_present = aif.done && aif.present;
    next_q.pme_d3cold  = aif.done && aif.present;
    next_q.aux_current = (aif.done && aif.present) ? `HIR_AUX_CURRENT_CAP
                                                   : `HIR_AUX_CURRENT_NONE;

    // The shared pin turns into the memory serial data output.
    next_q.pin_oe  = aif.oe;
    next_q.pin_out = aif.oe && i_cfg_mem_serial_out;
  end

  // State register; the whole block freezes while the clock enable is low.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
    end
    else if (i_ce)
    begin
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from the state register.
  assign o_serial_out_aux_sense_o  = q.pin_out;
  assign o_serial_out_aux_sense_oe = q.pin_oe;
  assign o_pm_wake_event_n_o       = q.wake_lvl;  // Never driven high.
  assign o_pm_wake_event_n_oe      = q.wake_pend;
  assign o_host_tx_en              = q.tx_en;
  assign o_host_tx_valid           = q.tx_valid;
  assign o_host_tx_data            = q.tx_data;
  assign o_core_rx_valid           = q.rx_valid;
  assign o_core_rx_data            = q.rx_data;
  assign o_cfg_ready               = q.cfg_ready;
  assign o_aux_power_present       = q.aux_present;
  assign o_pm_cap_d3cold_pme       = q.pme_d3cold;
  assign o_pm_cap_aux_current      = q.aux_current;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the sequencer, the isolation, the wake output, the capability bits and the shared pin.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_wake_req;
    i_wake_event && i_ce;
  endsequence

  sequence s_pull_low;
    o_pm_wake_event_n_oe && !o_pm_wake_event_n_o;
  endsequence

  sequence s_held_in_reset;
    !i_host_fundamental_reset_n && i_ce;
  endsequence

  sequence s_quiet_bus;
    !o_host_tx_en && !o_host_tx_valid && !o_core_rx_valid && !o_cfg_ready;
  endsequence

  a_wake_pulls_low:
    assert property (s_wake_req |=> s_pull_low)
    else $error("Wake event did not pull the wake output low.");

  a_wake_never_high:
    assert property (!o_pm_wake_event_n_o)
    else $error("Wake output driven high.");

  a_wake_holds:
    assert property ((o_pm_wake_event_n_oe && !i_main_power_good) |=> o_pm_wake_event_n_oe)
    else $error("Wake request dropped before main power returned.");

  a_iso_no_drive:
    assert property ((!i_bus_isolate_n && i_ce)
                     |=> (!o_host_tx_en && !o_host_tx_valid && !o_core_rx_valid))
    else $error("Host bus active while isolated.");

  a_reset_quiet:
    assert property (s_held_in_reset |=> s_quiet_bus)
    else $error("Host bus or configuration active during host reset.");

  a_ready_after_sense:
    assert property ($rose(o_cfg_ready) |-> (aif.done && $past(i_host_fundamental_reset_n)))
    else $error("Configuration accepted before reset release and sense.");

  a_caps_follow_aux:
    assert property ((aif.done && i_ce) |=> ((o_pm_cap_d3cold_pme == aif.present)
                     && (o_pm_cap_aux_current == (aif.present ? `HIR_AUX_CURRENT_CAP
                                                              : `HIR_AUX_CURRENT_NONE))))
    else $error("Capability bits disagree with the auxiliary result.");

  a_pin_carries_data:
    assert property ((aif.oe && i_ce) |=> (o_serial_out_aux_sense_oe
                     && (o_serial_out_aux_sense_o == $past(i_cfg_mem_serial_out))))
    else $error("Shared pin does not carry memory serial data.");

endmodule

`default_nettype wire

// ==== testbench/hir_board_model.sv ====
// Board and chipset model: pull-ups, shared pin level and main power restore.
`timescale 1ns/1ns
`default_nettype none

module hir_board_model
(
  input  wire logic       i_clk,
  input  wire logic       i_aux_up,
  input  wire logic [3:0] i_delay,
  input  wire logic       i_pin_o,
  input  wire logic       i_pin_oe,
  input  wire logic       i_wake_o,
  input  wire logic       i_wake_oe,
  output var  logic       o_pin,
  output var  logic       o_wake_line,
  output var  logic       o_power_good
);
  logic [3:0] wait_cnt = 4'h0;
  logic       power_good = 1'b0;

  // Device drive wins; otherwise the aux resistor sets the level.
  assign o_pin = i_pin_oe ? i_pin_o : i_aux_up;
  // Open drain wire: only a low is driven, the board pull-up gives the high.
  assign o_wake_line = i_wake_oe ? i_wake_o : 1'b1;

  // Power comes back a settable time after the wire falls, prompt or slow.
  assign o_power_good = power_good;
  always @(posedge i_clk)
  begin
    if (o_wake_line)
    begin
      wait_cnt <= 4'h0;
      power_good <= 1'b0;
    end
    else if (wait_cnt == i_delay)
      power_good <= 1'b1;
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
endmodule

`default_nettype wire

// ==== testbench/hir_top_tb_top.sv ====
// Self-checking bench for the reset, isolation, wake and aux sense block.
`timescale 1ns/1ns
`default_nettype none
`include "hir_params.svh"

module hir_top_tb_top;
  import hir_pkg::*;
  logic         clk = 1'b0, rst_n = 1'b0, hrst_n = 1'b1, iso_n = 1'b1;
  logic         rx_v = 1'b0, tx_v = 1'b0, wake = 1'b0, mem = 1'b0, aux_up = 1'b1;
  logic         ce = 1'b1;
  hir_byte_t    rx_d = 8'h00, tx_d = 8'h00, h_d, c_d;
  logic [3:0]   dly = 4'h0;
  logic         pin_o, pin_oe, wk_o, wk_oe, h_en, h_v, c_v, rdy, aux_p, pme;
  logic         pin, wline, pgood;
  hir_aux_cur_t aux_cur;
  int           n_mismatch = 0, check_count = 0;

  always #4 clk = ~clk;

  hir_top DUT (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_host_fundamental_reset_n(hrst_n), .i_bus_isolate_n(iso_n),
    .i_host_rx_valid(rx_v), .i_host_rx_data(rx_d), .i_core_tx_valid(tx_v),
    .i_core_tx_data(tx_d), .i_wake_event(wake), .i_main_power_good(pgood),
    .i_cfg_mem_serial_out(mem), .i_serial_out_aux_sense_i(pin),
    .o_serial_out_aux_sense_o(pin_o), .o_serial_out_aux_sense_oe(pin_oe),
    .o_pm_wake_event_n_o(wk_o), .o_pm_wake_event_n_oe(wk_oe), .o_host_tx_en(h_en),
    .o_host_tx_valid(h_v), .o_host_tx_data(h_d), .o_core_rx_valid(c_v),
    .o_core_rx_data(c_d), .o_cfg_ready(rdy), .o_aux_power_present(aux_p),
    .o_pm_cap_d3cold_pme(pme), .o_pm_cap_aux_current(aux_cur));

  hir_board_model BRD (.i_clk(clk), .i_aux_up(aux_up), .i_delay(dly), .i_pin_o(pin_o),
    .i_pin_oe(pin_oe), .i_wake_o(wk_o), .i_wake_oe(wk_oe), .o_pin(pin),
    .o_wake_line(wline), .o_power_good(pgood));

  ////////////////////////////////////////////////////////////////////////////////
  // Ends the run with the counts and the verdict.
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  // Wide enough that packed groups of outputs are compared whole, not cut.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait on ready or on the wake enable; returns the cycles spent.
  task automatic wait_sig(input bit sel, input logic want, output int i);
    for (i = 0; i < 300 && ((sel ? wk_oe : rdy) !== want); i++)
      step(1);
    if (i == 300)
    begin
      n_mismatch++;
      $display("Error at %0t: wait ran out, got %h expected %h", $time, ~want, want);
      tally_and_finish();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Power-on with or without aux power, then the pin turns to serial data.
  task automatic t_power_on(input logic up);
    int n;
    rst_n = 1'b0;
    aux_up = up;
    step(5);
    chk({h_en, h_v, c_v, rdy, aux_p, pme, pin_oe, wk_oe}, 8'h00);
    rst_n = 1'b1;
    wait_sig(1'b0, 1'b1, n);
    chk(n, `HIR_AUX_SETTLE_CYC + 2);
    step(1);
    chk(aux_p, up);
    chk({pme, aux_cur}, up ? {1'b1, `HIR_AUX_CURRENT_CAP} : 4'h0);
    aux_up = ~up;
    mem = 1'b1;
    step(1);
    chk({pin_oe, pin_o, pin}, 8'h07);
    mem = 1'b0;
    step(1);
    chk({pin_oe, pin_o, aux_p}, {2'b10, up});
    $display("t_power_on done");
  endtask

  // Back-to-back bytes both ways.
  task automatic t_data();
    tx_v = 1'b1;
    rx_v = 1'b1;
    tx_d = 8'hA5;
    rx_d = 8'h3C;
    step(1);
    tx_d = 8'h5A;
    rx_d = 8'hC3;
    chk({h_en, h_v, c_v, h_d[0]}, 8'h0F);
    chk(c_d, 8'h3C);
    step(1);
    tx_v = 1'b0;
    rx_v = 1'b0;
    chk(h_d, 8'h5A);
    chk(c_d, 8'hC3);
    step(1);
    chk({h_v, c_v, h_d, c_d}, 8'h00);
    $display("t_data done");
  endtask

  // Isolation drops traffic, wake still works, traffic returns after release.
  task automatic t_isolate();
    int n;
    iso_n = 1'b0;
    tx_v = 1'b1;
    rx_v = 1'b1;
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    chk({h_en, h_v, c_v, h_d, c_d}, 8'h00);
    chk({wk_oe, wk_o, wline}, 8'h04);
    iso_n = 1'b1;
    step(1);
    tx_v = 1'b0;
    rx_v = 1'b0;
    chk({h_en, h_v, c_v}, 8'h07);
    wait_sig(1'b1, 1'b0, n);
    $display("t_isolate done");
  endtask

  // Wake pulls the wire low until the board restores power.
  task automatic t_wake(input logic [3:0] d);
    int n;
    dly = d;
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    chk({wk_oe, wk_o, wline}, 8'h04);
    wait_sig(1'b1, 1'b0, n);
    chk(n >= d, 8'h01);
    chk({wk_oe, wline}, 8'h01);
    $display("t_wake done");
  endtask

  // Host reset refuses traffic, keeps the sense result, ready 2 edges on.
  task automatic t_host_rst();
    hrst_n = 1'b0;
    tx_v = 1'b1;
    step(1);
    chk({rdy, h_en, h_v, aux_p}, 8'h01);
    hrst_n = 1'b1;
    step(1);
    chk({rdy, h_v}, 8'h00);
    step(1);
    tx_v = 1'b0;
    chk(rdy, 8'h01);
    $display("t_host_rst done");
  endtask

  // Clock enable low freezes the block: a wake event is not taken, the held byte goes out once it returns.
  task automatic t_freeze();
    ce = 1'b0;
    wake = 1'b1;
    tx_v = 1'b1;
    tx_d = 8'h96;
    step(2);
    wake = 1'b0;
    chk({wk_oe, h_en, h_v, rdy}, 8'h01);
    ce = 1'b1;
    step(1);
    tx_v = 1'b0;
    chk({wk_oe, h_en, h_v}, 8'h03);
    chk(h_d, 8'h96);
    $display("t_freeze done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial
  begin
    t_power_on(1'b0);
    t_power_on(1'b1);
    t_data();
    t_isolate();
    t_wake(4'h0);
    t_wake(4'h9);
    t_host_rst();
    t_freeze();
    tally_and_finish();
  end
endmodule

`default_nettype wire
